// file: inc/cbio_pkg.sv
/*
  shared constants and types of the counter board i/o decode.
  assumes one 20 mhz system clock shared by the host bus and the counters.
*/
package cbio_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20_000_000;
  localparam int SLOW_SRC_HZ = 1_000_000;
  localparam int FAST_SRC_HZ = 5_000_000;
  localparam int SLOW_DIV = SYS_CLK_HZ / SLOW_SRC_HZ;
  localparam int FAST_DIV = SYS_CLK_HZ / FAST_SRC_HZ;

  // ----------------------------------------------------------------
  // sizes and address fields
  // ----------------------------------------------------------------
  localparam int MAX_CHIPS = 4;
  localparam int CTRS_PER_CHIP = 5;
  localparam int COUNTER_W = 16;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 11;
  localparam int BASE_SW_W = 7;
  localparam int BLOCK_LSB = 3;
  localparam int BLOCK_MSB = 9;
  localparam int CFG_SPACE_BIT = 10;
  localparam int IRQ_LO = 2;
  localparam int IRQ_HI = 7;

  // ----------------------------------------------------------------
  // register offsets within the block
  // ----------------------------------------------------------------
  localparam logic [10:0] OFS_CHIP1_DATA = 11'h000;
  localparam logic [10:0] OFS_CHIP1_CMD = 11'h001;
  localparam logic [10:0] OFS_CHIP2_DATA = 11'h002;
  localparam logic [10:0] OFS_CHIP2_CMD = 11'h003;
  localparam logic [10:0] OFS_CHIP3_DATA = 11'h004;
  localparam logic [10:0] OFS_CHIP3_CMD = 11'h005;
  localparam logic [10:0] OFS_CHIP4_DATA = 11'h006;
  localparam logic [10:0] OFS_CHIP4_CMD = 11'h007;
  localparam logic [10:0] OFS_FIRST_GROUP_CONFIG = 11'h400;
  localparam logic [10:0] OFS_SECOND_GROUP_CONFIG = 11'h401;

  // ----------------------------------------------------------------
  // configuration byte, bit 7 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wait_state_enable;
    logic [1:0] second_chip_source_sel;
    logic [1:0] first_chip_source_sel;
    logic [2:0] irq_level;
  } cbio_cfg_t;

  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [1:0] SRC_1MHZ = 2'h0;
  localparam logic [1:0] SRC_5MHZ = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;

  // ----------------------------------------------------------------
  // chip command port
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_POINT = 3'h0,
    CMD_ARM = 3'h1,
    CMD_DISARM = 3'h2,
    CMD_SAVE = 3'h3,
    CMD_LOAD = 3'h4
  } cbio_cmd_t;

  localparam logic [1:0] PTR_LOAD = 2'h0;
  localparam logic [1:0] PTR_HOLD = 2'h1;
  localparam logic [1:0] PTR_MODE = 2'h2;
  localparam logic [2:0] PTR_IDX_RESET = 3'h0;

  // counter mode byte: [1:0] source, [4:2] gate select
  localparam logic [1:0] CSRC_CHIP = 2'h0;
  localparam logic [1:0] CSRC_EXT = 2'h1;
  localparam logic [1:0] CSRC_PREV = 2'h2;
  localparam logic [1:0] CSRC_GATE = 2'h3;
  localparam logic [2:0] GATE_NONE = 3'h0;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  typedef struct packed {
    logic wrLoad;
    logic wrHold;
    logic wrMode;
    logic arm;
    logic disarm;
    logic save;
    logic loadNow;
  } cbio_ctl_t;
endpackage

// file: design/cbio_divider.sv
/*
  divide-by-n tick generator: one-cycle tick every DIV clocks.
  assumes DIV of two or more.
*/
`timescale 1ns/1ps
module cbio_divider import cbio_pkg::*;
#(
  parameter int DIV = SLOW_DIV
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  output logic tick
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
      tick <= (cnt == LAST);
    end
  end
endmodule

// file: design/cbio_counter.sv
/*
  one 16-bit counter with load, hold and mode registers, source and gate.
  assumes control strobes are one-cycle pulses from the chip port logic.
*/
`timescale 1ns/1ps
module cbio_counter import cbio_pkg::*;
#(
  parameter int IDX = 0
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic chipTick,
  input wire logic extTick,
  input wire logic prevOut,
  input wire logic [CTRS_PER_CHIP-1:0] gateIn,
  input wire logic [COUNTER_W-1:0] wrWord,
  input wire logic [BYTE_W-1:0] modeByte,
  input wire cbio_ctl_t ctl,
  output logic [COUNTER_W-1:0] loadVal,
  output logic [COUNTER_W-1:0] holdVal,
  output logic [BYTE_W-1:0] modeVal,
  output logic ctrOut
);
  logic [COUNTER_W-1:0] count;
  logic armed;
  logic prevLast;
  logic gateLast;

  // ----------------------------------------------------------------
  // source and gate routing
  // ----------------------------------------------------------------
  wire [1:0] srcSel = modeVal[1:0];
  wire [2:0] gateSel = modeVal[4:2];
  wire prevEdge = prevOut & ~prevLast;
  wire ownGateEdge = gateIn[IDX] & ~gateLast;
  wire srcTick = (srcSel == CSRC_CHIP) ? chipTick :
                 (srcSel == CSRC_EXT) ? extTick :
                 (srcSel == CSRC_PREV) ? prevEdge : ownGateEdge;
  wire gateInRange = (int'(gateSel) <= CTRS_PER_CHIP);
  wire [2:0] gateIdx = gateSel - 3'h1;
  wire gateOk = (gateSel == GATE_NONE) ? 1'b1 :
                (gateInRange ? gateIn[gateIdx] : 1'b0);
  wire countNow = armed & gateOk & srcTick;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      loadVal <= WORD_RESET;
      holdVal <= WORD_RESET;
      modeVal <= MODE_RESET;
      count <= WORD_RESET;
      armed <= 1'b0;
      ctrOut <= 1'b0;
      prevLast <= 1'b0;
      gateLast <= 1'b0;
    end
    else
    begin
      prevLast <= prevOut;
      gateLast <= gateIn[IDX];
      if (ctl.wrLoad)
        loadVal <= wrWord;
      if (ctl.wrHold)
        holdVal <= wrWord;
      else if (ctl.save)
        holdVal <= count;
      if (ctl.wrMode)
        modeVal <= {3'h0, modeByte[4:0]};
      if (ctl.arm)
        armed <= 1'b1;
      else if (ctl.disarm)
        armed <= 1'b0;
      if (ctl.loadNow)
        count <= loadVal;
      else if (countNow)
      begin
        if (count == 16'h0001)
        begin
          count <= loadVal;
          ctrOut <= ~ctrOut;
        end
        else
          count <= count - 16'h0001;
      end
    end
  end
endmodule

// file: design/cbio_io_decode.sv
/*
  i/o decode and register map of the counter board: chip ports,
  configuration registers, clock source and interrupt routing.
  assumes host strobes and pins are synchronous to sys_clk.
*/
`timescale 1ns/1ps
module cbio_io_decode import cbio_pkg::*;
#(
  parameter int NUM_CHIPS = 2
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [BASE_SW_W-1:0] baseSwitch,
  input wire logic [ADDR_W-1:0] ioAddr,
  input wire logic ioRdN,
  input wire logic ioWrN,
  input wire logic [BYTE_W-1:0] ioDataIn,
  output logic [BYTE_W-1:0] ioDataOut,
  output logic ioDataOeN,
  output logic waitStateReq,
  output logic [IRQ_HI:IRQ_LO] irqRequest,
  input wire logic [NUM_CHIPS/2-1:0] externalSourceInput,
  input wire logic [NUM_CHIPS/2-1:0] externalInterruptInput,
  input wire logic [NUM_CHIPS*CTRS_PER_CHIP-1:0] gateInput,
  output logic [NUM_CHIPS*CTRS_PER_CHIP-1:0] counterOutput
);
  localparam int NUM_GROUPS = NUM_CHIPS / 2;

  // ----------------------------------------------------------------
  // host address decode
  // ----------------------------------------------------------------
  logic rdNPrev;
  logic wrNPrev;
  cbio_cfg_t cfg [2];

  wire baseHit = (ioAddr[BLOCK_MSB:BLOCK_LSB] == baseSwitch);
  wire [1:0] chipSel = ioAddr[2:1];
  wire portSel = ioAddr[0];
  wire chipInBuild = (int'(chipSel) < NUM_CHIPS);
  wire chipHit = baseHit & ~ioAddr[CFG_SPACE_BIT] & chipInBuild;
  wire cfgInBuild = (int'(portSel) < NUM_GROUPS);
  wire cfgHit = baseHit & ioAddr[CFG_SPACE_BIT] & (chipSel == 2'h0) & cfgInBuild;
  wire rdStart = ~ioRdN & rdNPrev;
  wire wrStart = ~ioWrN & wrNPrev;
  wire accessStart = rdStart | wrStart;
  wire chipWaitEn = cfg[chipSel[1]].wait_state_enable;
  wire cfgWaitEn = cfg[portSel].wait_state_enable;
  wire next_waitStateReq = (accessStart & chipHit & chipWaitEn) | (wrStart & cfgHit & cfgWaitEn);

  // ----------------------------------------------------------------
  // per-chip strobes and read data
  // ----------------------------------------------------------------
  logic [MAX_CHIPS-1:0] cmdWr;
  logic [MAX_CHIPS-1:0] dataWr;
  logic [MAX_CHIPS-1:0] dataRd;
  logic [BYTE_W-1:0] chipData [MAX_CHIPS];
  logic [BYTE_W-1:0] chipStatus [MAX_CHIPS];
  logic chipTick [MAX_CHIPS];

  wire [BYTE_W-1:0] rdByte = portSel ? chipStatus[chipSel] : chipData[chipSel];
  wire next_ioDataOeN = ~(~ioRdN & chipHit);

  // ----------------------------------------------------------------
  // clock sources
  // ----------------------------------------------------------------
  logic slowTick;
  logic fastTick;
  logic [1:0] extPrev;
  logic [1:0] extTick;
  logic [1:0] irPrev;
  logic [1:0] irEdge;

  cbio_divider #(.DIV(SLOW_DIV)) u_slow
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick(slowTick)
  );

  cbio_divider #(.DIV(FAST_DIV)) u_fast
  (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick(fastTick)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_grp
      if (g < NUM_GROUPS)
      begin : g_on
        assign extTick[g] = externalSourceInput[g] & ~extPrev[g];
        assign irEdge[g] = externalInterruptInput[g] & ~irPrev[g];
        always_ff @(posedge sys_clk or negedge resetn)
        begin
          if (!resetn)
          begin
            extPrev[g] <= 1'b0;
            irPrev[g] <= 1'b0;
          end
          else
          begin
            extPrev[g] <= externalSourceInput[g];
            irPrev[g] <= externalInterruptInput[g];
          end
        end
      end
      else
      begin : g_off
        assign extTick[g] = 1'b0;
        assign irEdge[g] = 1'b0;
        assign extPrev[g] = 1'b0;
        assign irPrev[g] = 1'b0;
      end
      // config bytes: write-only, byte order bit 7 down to bit 0
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          cfg[g] <= cbio_cfg_t'(CFG_RESET);
        else if (wrStart & cfgHit & (int'(portSel) == g))
          cfg[g] <= cbio_cfg_t'(ioDataIn);
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // interrupt routing
  // ----------------------------------------------------------------
  genvar q;
  generate
    for (q = IRQ_LO; q <= IRQ_HI; q++)
    begin : g_irq
      localparam logic [2:0] LVL = 3'(q);
      wire hit = (irEdge[0] & (cfg[0].irq_level == LVL)) |
                 (irEdge[1] & (cfg[1].irq_level == LVL));
      always_ff @(posedge sys_clk or negedge resetn)
      begin
        if (!resetn)
          irqRequest[q] <= 1'b0;
        else
          irqRequest[q] <= hit;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // counter chips
  // ----------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < MAX_CHIPS; c++)
    begin : g_chip
      assign cmdWr[c] = wrStart & chipHit & (int'(chipSel) == c) & portSel;
      assign dataWr[c] = wrStart & chipHit & (int'(chipSel) == c) & ~portSel;
      assign dataRd[c] = rdStart & chipHit & (int'(chipSel) == c) & ~portSel;
      if (c < NUM_CHIPS)
      begin : g_on
        logic [2:0] ptrIdx;
        logic [1:0] ptrReg;
        logic hiPhase;
        logic [BYTE_W-1:0] lowShadow;
        logic [COUNTER_W-1:0] loadVal [CTRS_PER_CHIP];
        logic [COUNTER_W-1:0] holdVal [CTRS_PER_CHIP];
        logic [BYTE_W-1:0] modeVal [CTRS_PER_CHIP];
        logic [CTRS_PER_CHIP-1:0] ctrOut;
        cbio_ctl_t ctl [CTRS_PER_CHIP];

        wire [1:0] srcSel = (c % 2 == 1) ? cfg[c / 2].second_chip_source_sel :
                                          cfg[c / 2].first_chip_source_sel;
        wire [2:0] op = ioDataIn[7:5];
        wire [4:0] mask = ioDataIn[4:0];
        wire isMode = (ptrReg == PTR_MODE);
        wire ptrValid = (int'(ioDataIn[2:0]) < CTRS_PER_CHIP);
        wire [COUNTER_W-1:0] selWord = (ptrReg == PTR_HOLD) ? holdVal[ptrIdx] :
                                                              loadVal[ptrIdx];
        wire [COUNTER_W-1:0] wrWord = {ioDataIn, lowShadow};

        assign chipTick[c] = (srcSel == SRC_1MHZ) ? slowTick :
                             (srcSel == SRC_5MHZ) ? fastTick :
                             (srcSel == SRC_EXT) ? extTick[c / 2] : 1'b0;
        assign chipData[c] = isMode ? modeVal[ptrIdx] :
                             (hiPhase ? selWord[15:8] : selWord[7:0]);
        assign chipStatus[c] = {2'h0, hiPhase, ctrOut};
        assign counterOutput[c*CTRS_PER_CHIP +: CTRS_PER_CHIP] = ctrOut;

        // pointer selects counter and register, low byte first
        always_ff @(posedge sys_clk or negedge resetn)
        begin
          if (!resetn)
          begin
            ptrIdx <= PTR_IDX_RESET;
            ptrReg <= PTR_LOAD;
            hiPhase <= 1'b0;
            lowShadow <= 8'h00;
          end
          else if (cmdWr[c] & (op == CMD_POINT))
          begin
            if (ptrValid)
              ptrIdx <= ioDataIn[2:0];
            ptrReg <= ioDataIn[4:3];
            hiPhase <= 1'b0;
          end
          else if ((dataWr[c] | dataRd[c]) & ~isMode)
          begin
            hiPhase <= ~hiPhase;
            if (dataWr[c] & ~hiPhase)
              lowShadow <= ioDataIn;
          end
        end

        genvar i;
        for (i = 0; i < CTRS_PER_CHIP; i++)
        begin : g_ctr
          wire sel = (int'(ptrIdx) == i);
          assign ctl[i].wrLoad = dataWr[c] & sel & hiPhase & ~isMode & (ptrReg != PTR_HOLD);
          assign ctl[i].wrHold = dataWr[c] & sel & hiPhase & (ptrReg == PTR_HOLD);
          assign ctl[i].wrMode = dataWr[c] & sel & isMode;
          assign ctl[i].arm = cmdWr[c] & (op == CMD_ARM) & mask[i];
          assign ctl[i].disarm = cmdWr[c] & (op == CMD_DISARM) & mask[i];
          assign ctl[i].save = cmdWr[c] & (op == CMD_SAVE) & mask[i];
          assign ctl[i].loadNow = cmdWr[c] & (op == CMD_LOAD) & mask[i];

          cbio_counter #(.IDX(i)) u_ctr
          (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .chipTick(chipTick[c]),
            .extTick(extTick[c / 2]),
            .prevOut(ctrOut[(i + CTRS_PER_CHIP - 1) % CTRS_PER_CHIP]),
            .gateIn(gateInput[c*CTRS_PER_CHIP +: CTRS_PER_CHIP]),
            .wrWord(wrWord),
            .modeByte(ioDataIn),
            .ctl(ctl[i]),
            .loadVal(loadVal[i]),
            .holdVal(holdVal[i]),
            .modeVal(modeVal[i]),
            .ctrOut(ctrOut[i])
          );
        end
      end
      else
      begin : g_off
        assign chipData[c] = 8'h00;
        assign chipStatus[c] = 8'h00;
        assign chipTick[c] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // host bus outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdNPrev <= 1'b1;
      wrNPrev <= 1'b1;
      ioDataOut <= 8'h00;
      ioDataOeN <= 1'b1;
      waitStateReq <= 1'b0;
    end
    else
    begin
      rdNPrev <= ioRdN;
      wrNPrev <= ioWrN;
      if (rdStart & chipHit)
        ioDataOut <= rdByte;
      ioDataOeN <= next_ioDataOeN;
      waitStateReq <= next_waitStateReq;
    end
  end
endmodule

// file: sim/cbio_io_decode_asserts.sv
/*
  checker on the i/o decode ports: read answer, refusals, wait state, irq.
  assumes it is bound to cbio_io_decode and sees one clock domain.
*/
`timescale 1ns/1ps
module cbio_io_decode_asserts import cbio_pkg::*;
#(
  parameter int NUM_CHIPS = 2
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [BASE_SW_W-1:0] baseSwitch,
  input wire logic [ADDR_W-1:0] ioAddr,
  input wire logic ioRdN,
  input wire logic ioWrN,
  input wire logic [BYTE_W-1:0] ioDataOut,
  input wire logic ioDataOeN,
  input wire logic waitStateReq,
  input wire logic [IRQ_HI:IRQ_LO] irqRequest,
  input wire logic [NUM_CHIPS/2-1:0] externalInterruptInput
);
  // ----------------------------------------------------------------
  // claim decode and edge helpers
  // ----------------------------------------------------------------
  logic prevRdN;
  logic prevWrN;
  logic [NUM_CHIPS/2-1:0] prevIrqIn;
  wire logic inBlock = ioAddr[BLOCK_MSB:BLOCK_LSB] == baseSwitch;
  wire logic lowOfs = {1'b0, ioAddr[2:0]} < 4'(NUM_CHIPS * 2);
  wire logic chipHit = !ioAddr[CFG_SPACE_BIT] && inBlock && lowOfs;
  wire logic cfgOfs = ioAddr[2:1] == 2'h0 && (!ioAddr[0] || NUM_CHIPS == 4);
  wire logic cfgHit = ioAddr[CFG_SPACE_BIT] && inBlock && cfgOfs;
  wire logic rdStart = prevRdN && !ioRdN;
  wire logic wrStart = prevWrN && !ioWrN;
  wire logic rdClaim = rdStart && chipHit;
  wire logic accStart = rdClaim || (wrStart && (chipHit || cfgHit));
  wire logic irqEdge = |(externalInterruptInput & ~prevIrqIn);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prevRdN <= 1'b1;
      prevWrN <= 1'b1;
      prevIrqIn <= '0;
    end
    else
    begin
      prevRdN <= ioRdN;
      prevWrN <= ioWrN;
      prevIrqIn <= externalInterruptInput;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_read_answer: assert property (rdClaim |=> !ioDataOeN)
    else $error("claimed read not driven");
  a_refused_quiet: assert property (rdStart && !chipHit |=> ioDataOeN)
    else $error("refused read drove bus");
  a_oe_release: assert property ($rose(ioRdN) |=> ioDataOeN)
    else $error("data drive held after strobe");
  a_oe_needs_rd: assert property (!ioDataOeN |-> $past(ioRdN) == 1'b0)
    else $error("data drive without read strobe");
  a_data_hold: assert property (!$stable(ioDataOut) |-> $past(rdClaim))
    else $error("read data changed without read");
  a_wait_pulse: assert property (waitStateReq |=> !waitStateReq)
    else $error("wait request longer than one cycle");
  a_wait_cause: assert property (waitStateReq |-> $past(accStart))
    else $error("wait request without claimed access");
  a_irq_onehot: assert property ($onehot0(irqRequest))
    else $error("more than one irq line");
  a_irq_cause: assert property (|irqRequest |-> $past(irqEdge))
    else $error("irq without input rising edge");
endmodule

bind cbio_io_decode cbio_io_decode_asserts #(.NUM_CHIPS(NUM_CHIPS)) i_cbio_io_decode_asserts
(
  .sys_clk(sys_clk),
  .resetn(resetn),
  .baseSwitch(baseSwitch),
  .ioAddr(ioAddr),
  .ioRdN(ioRdN),
  .ioWrN(ioWrN),
  .ioDataOut(ioDataOut),
  .ioDataOeN(ioDataOeN),
  .waitStateReq(waitStateReq),
  .irqRequest(irqRequest),
  .externalInterruptInput(externalInterruptInput)
);

// file: sim/cbio_host_model.sv
/*
  host processor model: byte read and write cycles on the i/o bus.
  assumes the bench calls its tasks; strobes move at the falling edge.
*/
`timescale 1ns/1ps
module cbio_host_model import cbio_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [BYTE_W-1:0] ioDataOut,
  input wire logic ioDataOeN,
  output logic [ADDR_W-1:0] ioAddr,
  output logic ioRdN,
  output logic ioWrN,
  output logic [BYTE_W-1:0] ioDataIn
);
  initial
  begin
    ioAddr = 11'h000;
    ioRdN = 1'b1;
    ioWrN = 1'b1;
    ioDataIn = 8'h00;
  end

  // byte built bit 0 lsb to bit 7 msb, data bus driven with the inverted byte after
  task automatic busWr(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
    @(negedge sys_clk);
    ioAddr = a;
    ioDataIn = d;
    ioWrN = 1'b0;
    @(negedge sys_clk);
    ioWrN = 1'b1;
    ioDataIn = ~d;
  endtask

  task automatic busRd(input logic [ADDR_W-1:0] a, output logic [BYTE_W-1:0] d,
                       output logic oeN);
    @(negedge sys_clk);
    ioAddr = a;
    ioRdN = 1'b0;
    repeat (2) @(negedge sys_clk);
    d = ioDataOut;
    oeN = ioDataOeN;
    ioRdN = 1'b1;
  endtask

  // counter chosen by command before any data transfer
  task automatic selCtr(input logic [ADDR_W-1:0] cmdA, input logic [1:0] sel,
                        input logic [2:0] idx);
    busWr(cmdA, {CMD_POINT, sel, idx});
  endtask
endmodule

// file: sim/cbio_io_decode_tb_top.sv
/*
  self-checking bench of the i/o decode, twenty-channel build.
  assumes base switches at 0x300 and a 20 mhz clock.
*/
`timescale 1ns/1ps
module cbio_io_decode_tb_top import cbio_pkg::*;;
  localparam int NCH = 4;
  localparam logic [ADDR_W-1:0] BASE = 11'h300;
  logic sys_clk;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] ioAddr;
  logic ioRdN;
  logic ioWrN;
  logic [BYTE_W-1:0] ioDataIn;
  logic [BYTE_W-1:0] ioDataOut;
  logic ioDataOeN;
  logic waitStateReq;
  logic [IRQ_HI:IRQ_LO] irqRequest;
  logic [NCH/2-1:0] externalSourceInput = 2'h0;
  logic [NCH/2-1:0] externalInterruptInput = 2'h0;
  logic [NCH*CTRS_PER_CHIP-1:0] gateInput = 20'h00000;
  logic [NCH*CTRS_PER_CHIP-1:0] counterOutput;
  logic [7:0] rnd = 8'h26;
  int bad_count = 0;
  int n_tests = 0;
  int wsCnt = 0;
  int irqCnt [2:7] = '{0, 0, 0, 0, 0, 0};

  // ----------------------------------------------------------------
  // clock, instances, stimulus helpers
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  cbio_io_decode #(.NUM_CHIPS(NCH)) i_cbio_io_decode (.sys_clk(sys_clk), .resetn(resetn),
    .baseSwitch(7'h60), .ioAddr(ioAddr), .ioRdN(ioRdN), .ioWrN(ioWrN),
    .ioDataIn(ioDataIn), .ioDataOut(ioDataOut), .ioDataOeN(ioDataOeN),
    .waitStateReq(waitStateReq), .irqRequest(irqRequest),
    .externalSourceInput(externalSourceInput),
    .externalInterruptInput(externalInterruptInput), .gateInput(gateInput),
    .counterOutput(counterOutput));

  cbio_host_model i_cbio_host_model (.sys_clk(sys_clk), .ioDataOut(ioDataOut),
    .ioDataOeN(ioDataOeN), .ioAddr(ioAddr), .ioRdN(ioRdN), .ioWrN(ioWrN),
    .ioDataIn(ioDataIn));

  function automatic logic [7:0] lfsrNext(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // cycles between output toggles: two ticks of the chosen source, or 100 (the wait limit) for source 3
  function automatic logic [7:0] srcPeriod(input int src);
    case (src)
      0: return 8'(2 * SLOW_DIV);
      1: return 8'(2 * FAST_DIV);
      2: return 8'h0c;
      default: return 8'h64;
    endcase
  endfunction

  always @(negedge sys_clk)
  begin
    rnd <= lfsrNext(rnd);
    gateInput <= {rnd[3:0], rnd, rnd};
    if (waitStateReq === 1'b1)
      wsCnt++;
    for (int k = 2; k <= 7; k++)
      if (irqRequest[k] === 1'b1)
        irqCnt[k]++;
  end

  initial
  forever
  begin
    repeat (3) @(negedge sys_clk);
    externalSourceInput <= {rnd[0], ~externalSourceInput[0]};
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic waitToggle(output int cyc);
    logic o;
    cyc = 0;
    o = counterOutput[0];
    while (counterOutput[0] === o && cyc < 100)
    begin
      @(negedge sys_clk);
      cyc++;
    end
  endtask

  task automatic test_done();
    $display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    test_done();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] d;
    logic oe;
    logic [15:0] wrd;
    logic [1:0] sel;
    logic [2:0] idx;
    logic [ADDR_W-1:0] refused [3];
    int n;
    int c;
    refused = '{BASE + 11'h400, BASE + 11'h008, 11'h2f8};
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    chk({waitStateReq, irqRequest, ioDataOeN}, 8'h01, "idle outputs");
    for (int i = 0; i < NCH; i++)
    begin
      i_cbio_host_model.busRd(BASE + 11'(2 * i + 1), d, oe);
      chk(d, 8'h00, "status after reset");
      chk({7'h00, oe}, 8'h00, "status drive");
    end
    $display("test status done");
    for (int i = 0; i < NCH; i++)
    begin
      wrd = {rnd, lfsrNext(rnd)};
      idx = 3'(rnd % 5);
      sel = rnd[3] ? PTR_HOLD : PTR_LOAD;
      i_cbio_host_model.selCtr(BASE + 11'(2 * i + 1), sel, idx);
      i_cbio_host_model.busWr(BASE + 11'(2 * i), wrd[7:0]);
      i_cbio_host_model.busRd(BASE + 11'(2 * i + 1), d, oe);
      chk(d, 8'h20, "phase bit");
      i_cbio_host_model.busWr(BASE + 11'(2 * i), wrd[15:8]);
      i_cbio_host_model.selCtr(BASE + 11'(2 * i + 1), sel, idx);
      i_cbio_host_model.busRd(BASE + 11'(2 * i), d, oe);
      chk(d, wrd[7:0], "low byte");
      i_cbio_host_model.busRd(BASE + 11'(2 * i), d, oe);
      chk(d, wrd[15:8], "high byte");
    end
    $display("test data path done");
    foreach (refused[i])
    begin
      i_cbio_host_model.busRd(refused[i], d, oe);
      chk({7'h00, oe}, 8'h01, "refused read");
    end
    $display("test refusals done");
    i_cbio_host_model.busWr(BASE + 11'h400, 8'h80);
    i_cbio_host_model.busWr(BASE + 11'h401, 8'h00);
    n = wsCnt;
    i_cbio_host_model.busRd(BASE + 11'h400, d, oe);
    i_cbio_host_model.busRd(BASE + 11'h001, d, oe);
    @(negedge sys_clk);
    chk(8'(wsCnt - n), 8'h01, "wait first group");
    n = wsCnt;
    i_cbio_host_model.busRd(BASE + 11'h005, d, oe);
    @(negedge sys_clk);
    chk(8'(wsCnt - n), 8'h00, "wait second group");
    $display("test wait state done");
    for (int lvl = 0; lvl < 8; lvl++)
    begin
      i_cbio_host_model.busWr(BASE + 11'h400 + 11'(lvl % 2), 8'(lvl));
      irqCnt = '{0, 0, 0, 0, 0, 0};
      @(negedge sys_clk);
      externalInterruptInput[lvl % 2] = 1'b1;
      repeat (2) @(negedge sys_clk);
      externalInterruptInput[lvl % 2] = 1'b0;
      repeat (3) @(negedge sys_clk);
      for (int k = 2; k <= 7; k++)
        chk(8'(irqCnt[k]), (lvl == k) ? 8'h01 : 8'h00, "irq line count");
    end
    $display("test irq routing done");
    i_cbio_host_model.selCtr(BASE + 11'h001, PTR_LOAD, 3'h0);
    i_cbio_host_model.busWr(BASE, 8'h02);
    i_cbio_host_model.busWr(BASE, 8'h00);
    i_cbio_host_model.busWr(BASE + 11'h001, {CMD_LOAD, 5'h01});
    i_cbio_host_model.busWr(BASE + 11'h001, {CMD_ARM, 5'h01});
    for (int src = 0; src < 4; src++)
    begin
      i_cbio_host_model.busWr(BASE + 11'h400, 8'(src << 3));
      waitToggle(c);
      waitToggle(c);
      chk(8'(c), srcPeriod(src), "source period");
    end
    $display("test clock source done");
    i_cbio_host_model.busWr(BASE + 11'h001, {CMD_DISARM, 5'h01});
    i_cbio_host_model.busWr(BASE + 11'h400, 8'h00);
    waitToggle(c);
    chk(8'(c), 8'h64, "disarmed counter");
    wrd = {8'h00, rnd};
    i_cbio_host_model.selCtr(BASE + 11'h001, PTR_MODE, 3'h0);
    i_cbio_host_model.busWr(BASE, wrd[7:0]);
    i_cbio_host_model.busRd(BASE, d, oe);
    chk(d, {3'h0, wrd[4:0]}, "mode byte");
    $display("test mode and disarm done");
    test_done();
  end
endmodule
